// ===== pkg/amp_i2c_pkg.sv
// Shared constants and types for the amplifier two-wire control port.
// Assumes both ends run on one 100 MHz system clock.
`default_nettype none

package amp_i2c_pkg;

   // Seven-bit slave address that the device answers.
   localparam logic [6:0] DEV_ADDR      = 7'h36;
   // Last subaddress that allows single-byte access.
   localparam logic [7:0] LOW_SUB_LAST  = 8'h1F;
   // Bytes in one coefficient word.
   localparam int         WORD_BYTES    = 4;
   // Bits in one byte on the wire.
   localparam logic [3:0] BYTE_BITS     = 4'h8;

   // Clocking of the master end.
   localparam int         SYS_CLK_HZ    = 100_000_000;
   localparam int         SCL_FAST_HZ   = 400_000;
   // Quarter of a bus clock period, rounded up so the bus never runs above its rate.
   localparam int         QUARTER_CYC   = (SYS_CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);

   // Commands that the master end accepts from its user.
   typedef enum logic [1:0] {
      CMD_START,
      CMD_STOP,
      CMD_WRITE,
      CMD_READ
   } cmd_type;

endpackage

`default_nettype wire

// ===== pkg/amp_i2c_if.sv
// Wired-AND two-wire bus joining the master end and the device end.
// Assumes pull-ups: a line is high unless some party enables a low drive.
`timescale 1ns/1ps
`default_nettype none

interface amp_i2c_if;

   // Master drive of the clock and data lines.
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   // Device drive of the data line; the device never drives the clock.
   logic dev_sda_o;
   logic dev_sda_oe;
   // Resolved line levels.
   logic scl;
   logic sda;

   // Open-drain resolution with pull-ups.
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

   modport host (
      input  scl,
      input  sda,
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe
   );

   modport device (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe
   );

endinterface

`default_nettype wire

// ===== hw/amp_i2c_host.sv
// Master end of the two-wire control port: starts, stops, byte writes and reads.
// Assumes a user that issues commands in legal bus order.
`timescale 1ns/1ps
`default_nettype none

module amp_i2c_host #(
   parameter int QUARTER = amp_i2c_pkg::QUARTER_CYC
) (
   // Clock and reset.
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // Bus side.
   amp_i2c_if.host                   bus,
   // Command port.
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire amp_i2c_pkg::cmd_type cmd,
   input  wire logic [7:0]           cmd_data,
   input  wire logic                 cmd_ack,
   // Answer port.
   output logic                      rsp_valid,
   output logic [7:0]                rsp_data,
   output logic                      rsp_ack
);

   typedef enum logic {H_IDLE, H_RUN} hstate_type;

   hstate_type           st_r, st_nxt;
   amp_i2c_pkg::cmd_type op_r, op_nxt;
   logic [15:0]          div_r, div_nxt;
   logic [1:0]           q_r, q_nxt;
   logic [3:0]           bit_r, bit_nxt;
   logic [7:0]           sh_r, sh_nxt;
   logic [7:0]           rx_r, rx_nxt;
   logic                 ackb_r, ackb_nxt;
   logic                 got_r, got_nxt;
   logic                 scl_low_r, scl_low_nxt;
   logic                 sda_low_r, sda_low_nxt;
   logic                 vld_r, vld_nxt;
   logic                 sda_s1, sda_s2;
   logic                 tick;

   // Quarter-period enable from the divider.
   assign tick      = (div_r == 16'(QUARTER - 1));
   assign cmd_ready = (st_r == H_IDLE);
   assign rsp_valid = vld_r;
   assign rsp_data  = rx_r;
   assign rsp_ack   = got_r;
   // Open-drain drives: only a low is ever driven.
   assign bus.host_scl_o  = 1'b0;
   assign bus.host_scl_oe = scl_low_r;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = sda_low_r;

   // Next state: each bit takes four quarters; data changes only with the clock low, except in start and stop.
   always_comb
   begin
      st_nxt      = st_r;
      op_nxt      = op_r;
      div_nxt     = (st_r == H_RUN && !tick) ? div_r + 16'h0001 : 16'h0000;
      q_nxt       = q_r;
      bit_nxt     = bit_r;
      sh_nxt      = sh_r;
      rx_nxt      = rx_r;
      ackb_nxt    = ackb_r;
      got_nxt     = got_r;
      scl_low_nxt = scl_low_r;
      sda_low_nxt = sda_low_r;
      vld_nxt     = 1'b0;
      if (st_r == H_IDLE)
      begin
         if (cmd_valid)
         begin
            st_nxt   = H_RUN;
            op_nxt   = cmd;
            sh_nxt   = cmd_data;
            ackb_nxt = cmd_ack;
            q_nxt    = 2'h0;
            bit_nxt  = 4'h0;
         end
      end
      else if (tick)
      begin
         q_nxt = q_r + 2'h1;
         unique case (op_r)
            amp_i2c_pkg::CMD_START:
            begin
               unique case (q_r)
                  2'h0: sda_low_nxt = 1'b0;
                  2'h1: scl_low_nxt = 1'b0;
                  2'h2: sda_low_nxt = 1'b1;
                  2'h3:
                  begin
                     scl_low_nxt = 1'b1;
                     st_nxt      = H_IDLE;
                     vld_nxt     = 1'b1;
                  end
               endcase
            end
            amp_i2c_pkg::CMD_STOP:
            begin
               unique case (q_r)
                  2'h0: sda_low_nxt = 1'b1;
                  2'h1: scl_low_nxt = 1'b0;
                  2'h2: sda_low_nxt = 1'b0;
                  2'h3:
                  begin
                     st_nxt  = H_IDLE;
                     vld_nxt = 1'b1;
                  end
               endcase
            end
            default:
            begin
               unique case (q_r)
                  // Set data while the clock is low.
                  2'h0:
                  begin
                     if (bit_r < amp_i2c_pkg::BYTE_BITS)
                        sda_low_nxt = (op_r == amp_i2c_pkg::CMD_WRITE) & ~sh_r[7];
                     else
                        sda_low_nxt = (op_r == amp_i2c_pkg::CMD_READ) & ackb_r;
                  end
                  2'h1: scl_low_nxt = 1'b0;
                  // Sample while the clock is high.
                  2'h2:
                  begin
                     if (bit_r < amp_i2c_pkg::BYTE_BITS)
                     begin
                        rx_nxt = {rx_r[6:0], sda_s2};
                        sh_nxt = {sh_r[6:0], 1'b0};
                     end
                     else
                        got_nxt = ~sda_s2;
                  end
                  2'h3:
                  begin
                     scl_low_nxt = 1'b1;
                     bit_nxt     = bit_r + 4'h1;
                     if (bit_r == amp_i2c_pkg::BYTE_BITS)
                     begin
                        sda_low_nxt = 1'b0;
                        st_nxt      = H_IDLE;
                        vld_nxt     = 1'b1;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   // Registers and data-line synchroniser.
   always_ff @(posedge sys_clk)
   begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      if (!rst_n)
      begin
         st_r      <= H_IDLE;
         op_r      <= amp_i2c_pkg::CMD_START;
         div_r     <= 16'h0000;
         q_r       <= 2'h0;
         bit_r     <= 4'h0;
         sh_r      <= 8'h00;
         rx_r      <= 8'h00;
         ackb_r    <= 1'b0;
         got_r     <= 1'b0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         vld_r     <= 1'b0;
      end
      else
      begin
         st_r      <= st_nxt;
         op_r      <= op_nxt;
         div_r     <= div_nxt;
         q_r       <= q_nxt;
         bit_r     <= bit_nxt;
         sh_r      <= sh_nxt;
         rx_r      <= rx_nxt;
         ackb_r    <= ackb_nxt;
         got_r     <= got_nxt;
         scl_low_r <= scl_low_nxt;
         sda_low_r <= sda_low_nxt;
         vld_r     <= vld_nxt;
      end
   end

endmodule // amp_i2c_host

`default_nettype wire

// ===== hw/amp_i2c_dev.sv
// Device end of the two-wire control port: address match, acks, sub-addressed
// writes with whole-set checking, and sequential reads.
// Assumes the register store answers rd_word combinationally and need_words >= 1.
`timescale 1ns/1ps
`default_nettype none

module amp_i2c_dev #(
   parameter int MAX_WORDS = 5
) (
   // Clock and reset.
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   // Bus side.
   amp_i2c_if.device                      bus,
   // Set length of the current subaddress, in 32-bit words.
   output logic [7:0]                     cur_sub,
   input  wire logic [2:0]                need_words,
   // Write commit.
   output logic                           wr_valid,
   output logic [7:0]                     wr_sub,
   output logic [MAX_WORDS*32-1:0]        wr_data,
   output logic [4:0]                     wr_bytes,
   // Read fetch.
   output logic [2:0]                     rd_word_idx,
   input  wire logic [31:0]               rd_word
);

   localparam int DW = MAX_WORDS * 32;

   typedef enum logic [2:0] {ST_IDLE, ST_SKIP, ST_RX, ST_ACK, ST_LOAD, ST_TX, ST_MACK} phase_type;
   typedef enum logic [1:0] {R_ADDR, R_SUB, R_DATA} role_type;

   phase_type     ph_r, ph_nxt;
   role_type      role_r, role_nxt;
   logic [2:0]    bit_r, bit_nxt;
   logic [7:0]    sh_r, sh_nxt;
   logic [7:0]    sub_r, sub_nxt;
   logic [4:0]    cnt_r, cnt_nxt;
   logic          rw_r, rw_nxt;
   logic          drv_r, drv_nxt;
   logic [DW-1:0] dsh_r, dsh_nxt;
   logic          wv_r, wv_nxt;
   logic [7:0]    ws_r, ws_nxt;
   logic [DW-1:0] wd_r, wd_nxt;
   logic [4:0]    wb_r, wb_nxt;
   logic          scl_s1, scl_s2, scl_s3;
   logic          sda_s1, sda_s2, sda_s3;
   logic          rise, fall, start_c, stop_c;
   logic          low_sub;
   logic [7:0]    rx_byte;
   logic [7:0]    tx_byte;
   logic [4:0]    need_bytes;

   // Line events from synchronised samples; only the system clock is used, so
   // the port keeps working with the audio clocks absent.
   assign rise    = scl_s2 & ~scl_s3;
   assign fall    = ~scl_s2 & scl_s3;
   assign start_c = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_c  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   assign low_sub    = (sub_r <= amp_i2c_pkg::LOW_SUB_LAST);
   assign rx_byte    = {sh_r[6:0], sda_s2};
   assign need_bytes = {need_words, 2'b00};

   // Byte to send: a low subaddress gives its low byte, a word goes out MSB first.
   always_comb
   begin
      tx_byte = rd_word[7:0];
      if (!low_sub)
      begin
         unique case (cnt_r[1:0])
            2'h0: tx_byte = rd_word[31:24];
            2'h1: tx_byte = rd_word[23:16];
            2'h2: tx_byte = rd_word[15:8];
            2'h3: tx_byte = rd_word[7:0];
         endcase
      end
   end

   // Outputs. Only a low is driven on SDA, never anything on SCL.
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = drv_r;
   assign cur_sub        = sub_r;
   assign rd_word_idx    = cnt_r[4:2];
   assign wr_valid       = wv_r;
   assign wr_sub         = ws_r;
   assign wr_data        = wd_r;
   assign wr_bytes       = wb_r;

   // Protocol engine; no state waits on anything but bus edges, so no stretch.
   always_comb
   begin
      ph_nxt   = ph_r;
      role_nxt = role_r;
      bit_nxt  = bit_r;
      sh_nxt   = sh_r;
      sub_nxt  = sub_r;
      cnt_nxt  = cnt_r;
      rw_nxt   = rw_r;
      drv_nxt  = drv_r;
      dsh_nxt  = dsh_r;
      wv_nxt   = 1'b0;
      ws_nxt   = ws_r;
      wd_nxt   = wd_r;
      wb_nxt   = wb_r;
      if (start_c)
      begin
         // Any set still partial is dropped by clearing its count.
         ph_nxt   = ST_RX;
         role_nxt = R_ADDR;
         bit_nxt  = 3'h0;
         cnt_nxt  = 5'h00;
         dsh_nxt  = '0;
         drv_nxt  = 1'b0;
      end
      else if (stop_c)
      begin
         ph_nxt  = ST_IDLE;
         cnt_nxt = 5'h00;
         dsh_nxt = '0;
         drv_nxt = 1'b0;
      end
      else
      begin
         unique case (ph_r)
            ST_IDLE, ST_SKIP: ;
            ST_RX:
            begin
               if (rise)
               begin
                  sh_nxt  = rx_byte;
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7)
                  begin
                     ph_nxt = ST_ACK;
                     unique case (role_r)
                        R_ADDR:
                        begin
                           if (rx_byte[7:1] == amp_i2c_pkg::DEV_ADDR)
                           begin
                              rw_nxt   = rx_byte[0];
                              role_nxt = R_SUB;
                              cnt_nxt  = 5'h00;
                           end
                           else
                              ph_nxt = ST_SKIP;
                        end
                        R_SUB:
                        begin
                           sub_nxt  = rx_byte;
                           role_nxt = R_DATA;
                           cnt_nxt  = 5'h00;
                        end
                        R_DATA:
                        begin
                           // Each byte is accepted; there is no length ceiling.
                           dsh_nxt = {dsh_r[DW-9:0], rx_byte};
                           if (low_sub)
                           begin
                              wv_nxt  = 1'b1;
                              ws_nxt  = sub_r;
                              wd_nxt  = {{(DW-8){1'b0}}, rx_byte};
                              wb_nxt  = 5'h01;
                              dsh_nxt = '0;
                              sub_nxt = sub_r + 8'h01;
                           end
                           else if (cnt_r + 5'h01 == need_bytes)
                           begin
                              wv_nxt  = 1'b1;
                              ws_nxt  = sub_r;
                              wd_nxt  = {dsh_r[DW-9:0], rx_byte};
                              wb_nxt  = need_bytes;
                              dsh_nxt = '0;
                              sub_nxt = sub_r + 8'h01;
                              cnt_nxt = 5'h00;
                           end
                           else
                              cnt_nxt = cnt_r + 5'h01;
                        end
                        default: ph_nxt = ST_SKIP;
                     endcase
                  end
               end
            end
            ST_ACK:
            begin
               // Pull low from the fall after the byte to the fall after the ack clock.
               if (fall)
               begin
                  if (!drv_r)
                     drv_nxt = 1'b1;
                  else if (rw_r && role_r == R_SUB)
                  begin
                     // A read puts its first bit out at this fall, so no clock is lost.
                     sh_nxt  = {tx_byte[6:0], 1'b0};
                     drv_nxt = ~tx_byte[7];
                     bit_nxt = 3'h0;
                     ph_nxt  = ST_TX;
                  end
                  else
                  begin
                     drv_nxt = 1'b0;
                     bit_nxt = 3'h0;
                     ph_nxt  = ST_RX;
                  end
               end
            end
            ST_LOAD:
            begin
               if (fall)
               begin
                  sh_nxt  = {tx_byte[6:0], 1'b0};
                  drv_nxt = ~tx_byte[7];
                  bit_nxt = 3'h0;
                  ph_nxt  = ST_TX;
               end
            end
            ST_TX:
            begin
               if (fall)
               begin
                  if (bit_r == 3'h7)
                  begin
                     drv_nxt = 1'b0;
                     ph_nxt  = ST_MACK;
                  end
                  else
                  begin
                     drv_nxt = ~sh_r[7];
                     sh_nxt  = {sh_r[6:0], 1'b0};
                     bit_nxt = bit_r + 3'h1;
                  end
               end
            end
            ST_MACK:
            begin
               if (rise)
               begin
                  if (!sda_s2)
                  begin
                     ph_nxt = ST_LOAD;
                     if (low_sub)
                        sub_nxt = sub_r + 8'h01;
                     else if (cnt_r + 5'h01 == need_bytes)
                     begin
                        sub_nxt = sub_r + 8'h01;
                        cnt_nxt = 5'h00;
                     end
                     else
                        cnt_nxt = cnt_r + 5'h01;
                  end
                  else
                     ph_nxt = ST_SKIP;
               end
            end
            default: ph_nxt = ST_IDLE;
         endcase
      end
   end

   // Registers and line synchronisers.
   always_ff @(posedge sys_clk)
   begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      if (!rst_n)
      begin
         ph_r   <= ST_IDLE;
         role_r <= R_ADDR;
         bit_r  <= 3'h0;
         sh_r   <= 8'h00;
         sub_r  <= 8'h00;
         cnt_r  <= 5'h00;
         rw_r   <= 1'b0;
         drv_r  <= 1'b0;
         dsh_r  <= '0;
         wv_r   <= 1'b0;
         ws_r   <= 8'h00;
         wd_r   <= '0;
         wb_r   <= 5'h00;
      end
      else
      begin
         ph_r   <= ph_nxt;
         role_r <= role_nxt;
         bit_r  <= bit_nxt;
         sh_r   <= sh_nxt;
         sub_r  <= sub_nxt;
         cnt_r  <= cnt_nxt;
         rw_r   <= rw_nxt;
         drv_r  <= drv_nxt;
         dsh_r  <= dsh_nxt;
         wv_r   <= wv_nxt;
         ws_r   <= ws_nxt;
         wd_r   <= wd_nxt;
         wb_r   <= wb_nxt;
      end
   end

endmodule // amp_i2c_dev

`default_nettype wire

// ===== dv/amp_i2c_checker.sv
// Assertions on the two-wire bus between the master end and the device end.
// Assumes the master end runs with QUARTER = 4, so the clock stays high 8 cycles.
`timescale 1ns/1ps
`default_nettype none

module amp_i2c_checker (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Drives and resolved lines of the bus.
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_r, sda_r, first_r, wr_r, rd_r, nak_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic       rise, strt, stp;

   // Bus events seen from the sampled line levels.
   assign rise = scl & ~scl_r;
   assign strt = scl & scl_r & sda_r & ~sda;
   assign stp  = scl & scl_r & ~sda_r & sda;

   // Tracks the bit count, the byte shifted in and the direction of the frame.
   always_ff @(posedge sys_clk)
   begin
      scl_r <= rst_n ? scl : 1'b1;
      sda_r <= rst_n ? sda : 1'b1;
      if (!rst_n || strt || stp)
      begin
         bit_r   <= 4'h0;
         first_r <= strt;
         wr_r    <= 1'b0;
         rd_r    <= 1'b0;
         nak_r   <= 1'b0;
      end
      else if (rise && bit_r == 4'h8)
      begin
         bit_r   <= 4'h0;
         first_r <= 1'b0;
         wr_r    <= first_r ? dev_sda_oe & ~sh_r[0] : wr_r;
         rd_r    <= first_r ? dev_sda_oe & sh_r[0] : rd_r & ~sda;
         nak_r   <= nak_r | (rd_r & sda);
      end
      else if (rise)
      begin
         bit_r <= bit_r + 4'h1;
         sh_r  <= {sh_r[6:0], sda};
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_drive_low:
   assert property (dev_sda_oe |-> !dev_sda_o) else $error("device drove data high");
   a_no_stretch:
   assert property (!host_scl_oe |=> scl || host_scl_oe) else $error("clock held low");
   a_sda_scl_low:
   assert property ($changed(dev_sda_oe) |-> !scl) else $error("data moved with clock high");
   a_ack_hold:
   assert property ($rose(scl) && dev_sda_oe |-> (scl && dev_sda_oe) [*7])
      else $error("ack not held over clock high");
   a_addr_ack:
   assert property (rise && bit_r == 4'h8 && first_r |->
      dev_sda_oe == (sh_r[7:1] == amp_i2c_pkg::DEV_ADDR)) else $error("address ack wrong");
   a_data_ack:
   assert property (rise && bit_r == 4'h8 && !first_r && wr_r |-> dev_sda_oe)
      else $error("written byte not acked");
   a_read_release:
   assert property (rise && bit_r == 4'h8 && rd_r |-> !dev_sda_oe)
      else $error("device drove master ack slot");
   a_nack_idle:
   assert property (nak_r |-> !dev_sda_oe) else $error("device drove after nack");
   a_host_low:
   assert property (!(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o))
      else $error("master drove a line high");

endmodule // amp_i2c_checker

`default_nettype wire

// ===== dv/amp_control_i2c_slave_tb_top.sv
// Bench joining the master end to the device end, with a byte model of both.
// Assumes the package, the interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) n_compared++; if ((gt) !== (ex)) begin $display("unexpected %s exp %0h got %0h", nm, ex, gt); n_fail++; end

module amp_control_i2c_slave_tb_top;
   localparam amp_i2c_pkg::cmd_type c_start = amp_i2c_pkg::CMD_START;
   localparam amp_i2c_pkg::cmd_type c_stop  = amp_i2c_pkg::CMD_STOP;
   localparam amp_i2c_pkg::cmd_type c_write = amp_i2c_pkg::CMD_WRITE;
   localparam amp_i2c_pkg::cmd_type c_read  = amp_i2c_pkg::CMD_READ;
   logic                 sys_clk, rst_n, cmd_valid, cmd_ready, cmd_ack;
   logic                 rsp_valid, rsp_ack, wr_valid;
   amp_i2c_pkg::cmd_type cmd;
   logic [7:0]           cmd_data, rsp_data, cur_sub, wr_sub;
   logic [159:0]         wr_data;
   logic [4:0]           wr_bytes;
   logic [2:0]           need_words, rd_word_idx;
   logic [31:0]          rd_word;
   int                   n_fail, n_compared;
   logic [7:0]           e_sub[$];
   logic [159:0]         e_dat[$];
   logic [4:0]           e_n[$];

   amp_i2c_if bus ();
   amp_i2c_host #(.QUARTER(4)) u_amp_i2c_host (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_data(cmd_data),
      .cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   amp_i2c_dev u_amp_i2c_dev (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .cur_sub(cur_sub),
      .need_words(need_words), .wr_valid(wr_valid), .wr_sub(wr_sub), .wr_data(wr_data),
      .wr_bytes(wr_bytes), .rd_word_idx(rd_word_idx), .rd_word(rd_word));
   amp_i2c_checker u_amp_i2c_checker (.sys_clk(sys_clk), .rst_n(rst_n),
      .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
      .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
      .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));

   // Set length in words: odd high subaddresses take two words.
   function automatic logic [2:0] nw(input logic [7:0] s);
      return (s > 8'h1F && s[0]) ? 3'h2 : 3'h1;
   endfunction
   // Register store content; low subaddresses keep upper bits zero.
   function automatic logic [31:0] wv(input logic [7:0] s, input logic [2:0] i);
      return (s < 8'h20) ? {24'h0, s ^ 8'h3C} : {s, 5'h0, i, ~s, 8'hC3};
   endfunction
   assign need_words = nw(cur_sub);
   assign rd_word    = wv(cur_sub, rd_word_idx);

   // Clock of 100 MHz.
   always #5 sys_clk = ~sys_clk;

   // Each commit must match the oldest expected set.
   always @(negedge sys_clk)
   begin
      if (wr_valid === 1'b1)
      begin
         `CHK("commit expected", 1'b1, e_sub.size() != 0)
         if (e_sub.size() != 0)
         begin
            `CHK("wr_sub", e_sub[0], wr_sub)
            `CHK("wr_data", e_dat[0], wr_data)
            `CHK("wr_bytes", e_n[0], wr_bytes)
            void'(e_sub.pop_front());
            void'(e_dat.pop_front());
            void'(e_n.pop_front());
         end
      end
   end

   // One master command, waited on under a bound.
   task automatic op(input amp_i2c_pkg::cmd_type c, input logic [7:0] d, input logic a);
      int k;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd       <= c;
      cmd_data  <= d;
      cmd_ack   <= a;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(negedge sys_clk);
      `CHK("cmd_ready", 1'b0, cmd_ready)
      for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++)
         @(negedge sys_clk);
      if (k == 3000)
      begin
         n_fail++;
         give_verdict();
      end
   endtask

   // Addressed write of n random bytes; the model groups them into sets.
   task automatic wseq(input logic [7:0] sub, input int n, input bit rs);
      logic [7:0]   b, s;
      logic [159:0] v;
      logic [4:0]   c;
      s = sub;
      v = '0;
      c = 5'h0;
      op(c_start, 8'h00, 1'b0);
      op(c_write, 8'h6C, 1'b0);
      `CHK("addr ack", 1'b1, rsp_ack)
      op(c_write, sub, 1'b0);
      `CHK("sub ack", 1'b1, rsp_ack)
      repeat (n)
      begin
         b = 8'($urandom);
         v = {v[151:0], b};
         c++;
         if (c == ((s > 8'h1F) ? {nw(s), 2'b00} : 5'h1))
         begin
            e_sub.push_back(s);
            e_dat.push_back(v);
            e_n.push_back(c);
            s++;
            v = '0;
            c = 5'h0;
         end
         op(c_write, b, 1'b0);
         `CHK("data ack", 1'b1, rsp_ack)
      end
      op(rs ? c_start : c_stop, 8'h00, 1'b0);
      `CHK("left over", 0, e_sub.size())
   endtask

   // Subaddress write, repeated start, then n reads with a final nack.
   task automatic rseq(input logic [7:0] sub, input int n);
      logic [7:0]  s;
      logic [31:0] t;
      logic [2:0]  w;
      int          bi, i;
      s = sub;
      w = 3'h0;
      bi = 0;
      op(c_start, 8'h00, 1'b0);
      op(c_write, 8'h6C, 1'b0);
      op(c_write, sub, 1'b0);
      op(c_start, 8'h00, 1'b0);
      op(c_write, 8'h6D, 1'b0);
      `CHK("read addr ack", 1'b1, rsp_ack)
      for (i = 0; i < n; i++)
      begin
         op(c_read, 8'h00, i < n - 1);
         t = wv(s, w) >> ((s > 8'h1F) ? 24 - 8 * bi : 0);
         `CHK("read data", t[7:0], rsp_data)
         bi = (s > 8'h1F) ? bi + 1 : 4;
         if (bi == 4)
         begin
            bi = 0;
            w++;
         end
         if (w == nw(s))
         begin
            w = 3'h0;
            s++;
         end
      end
      op(c_stop, 8'h00, 1'b0);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Main sequence: boundary writes, restart drop, foreign address, reads, random writes.
   initial
   begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd = c_start;
      cmd_data = 8'h00;
      cmd_ack = 1'b0;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(92));
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      wseq(8'h1E, 3, 1'b0);
      wseq(8'h21, 14, 1'b1);
      op(c_write, 8'h6E, 1'b0);
      `CHK("foreign ack", 1'b0, rsp_ack)
      op(c_write, 8'h42, 1'b0);
      op(c_stop, 8'h00, 1'b0);
      rseq(8'h1E, 3);
      rseq(8'h21, 9);
      repeat (4) wseq(8'($urandom), $urandom_range(1, 12), 1'b0);
      give_verdict();
   end

endmodule // amp_control_i2c_slave_tb_top

`default_nettype wire
